// *** include/crm_pkg.sv ***
// Shared types and constants of the control-register bus master.
// Assumes bit 0 is the most significant bit of every address and data bus.
`default_nettype none

package crm_pkg;

	// ------------------------------------------------------------
	// Bus widths and reset values
	// ------------------------------------------------------------
	localparam int CR_ADDR_W = 10;
	localparam int CR_DATA_W = 32;

	typedef logic [0:CR_ADDR_W-1] crm_addr_t;
	typedef logic [0:CR_DATA_W-1] crm_data_t;

	localparam crm_addr_t CR_ADDR_RST  = 10'h000;
	localparam crm_data_t CR_DATA_ZERO = 32'h0000_0000;

	// ------------------------------------------------------------
	// Timeout counter
	// ------------------------------------------------------------
	localparam int           TMO_CYCLES = 64;
	localparam int           TMO_W      = 7;
	localparam logic [6:0]   TMO_ZERO   = 7'h00;
	localparam logic [6:0]   TMO_ONE    = 7'h01;
	localparam logic [6:0]   TMO_LAST   = 7'(TMO_CYCLES - 1);

	// ------------------------------------------------------------
	// Command carried from the core side into the master
	// ------------------------------------------------------------
	typedef struct packed {
		logic      write;
		crm_addr_t addr;
		crm_data_t wdata;
	} crm_cmd_t;

	localparam crm_cmd_t CMD_RST = '{write: 1'b0, addr: CR_ADDR_RST, wdata: CR_DATA_ZERO};

endpackage : crm_pkg

`default_nettype wire

// *** rtl/crm_sync.sv ***
// Three-stage level synchroniser with a stability filter.
// Assumes d_in is a level from another clock domain or a pin.
`default_nettype none

module crm_sync
	import crm_pkg::*;
(
	input  wire logic clk_in,
	input  wire logic rstn_in,
	input  wire logic d_in,
	output var  logic q_out
);

	logic s1_q;
	logic s2_q;
	logic s3_q;
	logic q_d;

	// First stage feeds only the second one
	always_comb begin
		q_d = (s2_q == s3_q) ? s3_q : q_out;
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			s1_q  <= 1'b0;
			s2_q  <= 1'b0;
			s3_q  <= 1'b0;
			q_out <= 1'b0;
		end else begin
			s1_q  <= d_in;
			s2_q  <= s1_q;
			s3_q  <= s2_q;
			q_out <= q_d;
		end
	end

endmodule : crm_sync

`default_nettype wire

// *** rtl/crm_tmo.sv ***
// Acknowledge timeout counter, counting core clock cycles.
// Assumes start_in pulses before the request rises and run_in covers the wait.
`default_nettype none

module crm_tmo
	import crm_pkg::*;
(
	input  wire logic clk_in,
	input  wire logic rstn_in,
	input  wire logic start_in,
	input  wire logic run_in,
	output var  logic hit_out
);

	logic [TMO_W-1:0] cnt_q;
	logic [TMO_W-1:0] cnt_d;

	always_comb begin
		cnt_d = cnt_q;
		if (start_in) begin
			cnt_d = TMO_ZERO;
		end else if (run_in && (cnt_q != TMO_LAST)) begin
			cnt_d = cnt_q + TMO_ONE;
		end
		hit_out = run_in && (cnt_q == TMO_LAST);
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			cnt_q <= TMO_ZERO;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	AST_CNT_CLEAR: assert property (@(posedge clk_in) disable iff (!rstn_in)
		start_in |=> (cnt_q == TMO_ZERO)) else $error("timeout count not cleared");

endmodule : crm_tmo

`default_nettype wire

// *** rtl/crm_master.sv ***
// Control-register bus master: core-clocked port and bus-clocked port.
// Assumes peripherals keep acknowledge high until the request falls and that
// the bus clock has edges aligned to the peripherals' clocks.
//
// How it works
// - Core variant: read request rises one cycle after address, drops two after ack.
// - Core variant: write request rises one cycle after address/data, drops two after ack.
// - Bus variant: read request rises with or one cycle after address, drops later.
// - Bus variant: write request rises with or one cycle after address/data.
// - A raised request ends only on acknowledge or timeout.
// - Both requests are low during reset.
// - Address is valid and stable throughout a request.
// - New address only after previous acknowledge was low one cycle.
// - Write data carries the value on writes, zero on reads.
// - Write data is all zeros during reset.
// - At most 64 core cycles wait; timeout ends access and raises cmd_timeout_out.
// - Read data is captured when acknowledge is seen.
// - Bus variant runs through resynchronising registers on the bus clock.
// - Read and write requests are never high together.
// - Master and peripheral clock edges must coincide on the slower clock.
`default_nettype none

module crm_master
	import crm_pkg::*;
(
	input  wire logic      sys_clk_in,
	input  wire logic      rstn_in,
	input  wire logic      cr_bus_clk_in,
	input  wire logic      mode_bus_clk_in,
	// Core-side command port
	input  wire logic      cmd_valid_in,
	input  wire crm_cmd_t  cmd_in,
	output var  logic      cmd_ready_out,
	output var  logic      cmd_done_out,
	output var  logic      cmd_timeout_out,
	output var  crm_data_t cmd_rdata_out,
	// Core-clocked bus port
	output var  logic      cr_read_req_out,
	output var  logic      cr_write_req_out,
	output var  crm_addr_t cr_addr_out,
	output var  crm_data_t cr_wdata_out,
	input  wire logic      cr_ack_in,
	input  wire crm_data_t cr_rdata_in,
	// Bus-clocked port
	output var  logic      cr_read_req_sync_out,
	output var  logic      cr_write_req_sync_out,
	output var  crm_addr_t cr_addr_sync_out,
	output var  crm_data_t cr_wdata_sync_out,
	input  wire logic      cr_ack_sync_in,
	input  wire crm_data_t cr_rdata_sync_in
);

	// ------------------------------------------------------------
	// Variant strap, caught once after reset release
	// ------------------------------------------------------------
	logic mode_lvl;
	logic settle_lvl;
	logic mode_q;
	logic mode_d;
	logic cap_q;
	logic cap_d;

	crm_sync u_mode_sync (
		.clk_in  (sys_clk_in),
		.rstn_in (rstn_in),
		.d_in    (mode_bus_clk_in),
		.q_out   (mode_lvl)
	);

	// Twin of the strap path: rises once the reset zeros have flushed out
	crm_sync u_cap_sync (
		.clk_in  (sys_clk_in),
		.rstn_in (rstn_in),
		.d_in    (1'b1),
		.q_out   (settle_lvl)
	);

	always_comb begin
		cap_d  = settle_lvl;
		mode_d = cap_q ? mode_q : mode_lvl;
	end

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			cap_q  <= 1'b0;
			mode_q <= 1'b0;
		end else begin
			cap_q  <= cap_d;
			mode_q <= mode_d;
		end
	end

	// ------------------------------------------------------------
	// Core-domain sequencer
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE, ST_ADDR, ST_REQ, ST_HOLD, ST_WAITLOW, ST_XFER, ST_XABORT
	} crm_core_st_t;

	crm_core_st_t state_q;
	crm_core_st_t state_d;
	logic         op_wr_q;
	logic         op_wr_d;
	crm_cmd_t     hold_q;
	crm_cmd_t     hold_d;
	logic         req_tgl_q;
	logic         req_tgl_d;
	logic         abt_tgl_q;
	logic         abt_tgl_d;
	logic         done_seen_q;
	logic         done_seen_d;
	logic         rd_d;
	logic         wr_d;
	crm_addr_t    addr_d;
	crm_data_t    wdata_d;
	logic         ready_d;
	logic         done_d;
	logic         tmo_d;
	crm_data_t    rdata_d;
	logic         tmo_start;
	logic         tmo_run;
	logic         tmo_hit;
	logic         done_lvl;
	logic         done_evt;
	crm_data_t    b_rdata_q;

	crm_tmo u_tmo (
		.clk_in   (sys_clk_in),
		.rstn_in  (rstn_in),
		.start_in (tmo_start),
		.run_in   (tmo_run),
		.hit_out  (tmo_hit)
	);

	assign done_evt = (done_lvl != done_seen_q);

	always_comb begin
		state_d     = state_q;
		op_wr_d     = op_wr_q;
		hold_d      = hold_q;
		req_tgl_d   = req_tgl_q;
		abt_tgl_d   = abt_tgl_q;
		done_seen_d = done_lvl;
		addr_d      = cr_addr_out;
		wdata_d     = cr_wdata_out;
		rdata_d     = cmd_rdata_out;
		tmo_d       = cmd_timeout_out;
		done_d      = 1'b0;
		tmo_start   = 1'b0;
		tmo_run     = 1'b0;
		unique case (state_q)
			ST_IDLE: begin
				if (cmd_valid_in) begin
					op_wr_d = cmd_in.write;
					tmo_d   = 1'b0;
					if (mode_q) begin
						hold_d       = cmd_in;
						hold_d.wdata = cmd_in.write ? cmd_in.wdata : CR_DATA_ZERO;
						req_tgl_d    = ~req_tgl_q;
						tmo_start    = 1'b1;
						state_d      = ST_XFER;
					end else begin
						addr_d  = cmd_in.addr;
						wdata_d = cmd_in.write ? cmd_in.wdata : CR_DATA_ZERO;
						state_d = ST_ADDR;
					end
				end
			end
			ST_ADDR: begin
				tmo_start = 1'b1;
				state_d   = ST_REQ;
			end
			ST_REQ: begin
				tmo_run = 1'b1;
				if (cr_ack_in) begin
					if (!op_wr_q) begin
						rdata_d = cr_rdata_in;
					end
					state_d = ST_HOLD;
				end else if (tmo_hit) begin
					tmo_d   = 1'b1;
					state_d = ST_WAITLOW;
				end
			end
			ST_HOLD: begin
				state_d = ST_WAITLOW;
			end
			ST_WAITLOW: begin
				if (!cr_ack_in) begin
					done_d  = 1'b1;
					state_d = ST_IDLE;
				end
			end
			ST_XFER: begin
				tmo_run = 1'b1;
				if (done_evt) begin
					if (!op_wr_q) begin
						rdata_d = b_rdata_q;
					end
					done_d  = 1'b1;
					state_d = ST_IDLE;
				end else if (tmo_hit) begin
					abt_tgl_d = ~abt_tgl_q;
					tmo_d     = 1'b1;
					state_d   = ST_XABORT;
				end
			end
			ST_XABORT: begin
				if (done_evt) begin
					done_d  = 1'b1;
					state_d = ST_IDLE;
				end
			end
		endcase
		rd_d    = !op_wr_d && ((state_d == ST_REQ) || (state_d == ST_HOLD));
		wr_d    = op_wr_d && ((state_d == ST_REQ) || (state_d == ST_HOLD));
		ready_d = (state_d == ST_IDLE);
	end

	// Outputs and state all reset to inactive, data buses to zero
	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state_q          <= ST_IDLE;
			op_wr_q          <= 1'b0;
			hold_q           <= CMD_RST;
			req_tgl_q        <= 1'b0;
			abt_tgl_q        <= 1'b0;
			done_seen_q      <= 1'b0;
			cr_read_req_out  <= 1'b0;
			cr_write_req_out <= 1'b0;
			cr_addr_out      <= CR_ADDR_RST;
			cr_wdata_out     <= CR_DATA_ZERO;
			cmd_ready_out    <= 1'b0;
			cmd_done_out     <= 1'b0;
			cmd_timeout_out  <= 1'b0;
			cmd_rdata_out    <= CR_DATA_ZERO;
		end else begin
			state_q          <= state_d;
			op_wr_q          <= op_wr_d;
			hold_q           <= hold_d;
			req_tgl_q        <= req_tgl_d;
			abt_tgl_q        <= abt_tgl_d;
			done_seen_q      <= done_seen_d;
			cr_read_req_out  <= rd_d;
			cr_write_req_out <= wr_d;
			cr_addr_out      <= addr_d;
			cr_wdata_out     <= wdata_d;
			cmd_ready_out    <= ready_d;
			cmd_done_out     <= done_d;
			cmd_timeout_out  <= tmo_d;
			cmd_rdata_out    <= rdata_d;
		end
	end

	// ------------------------------------------------------------
	// Bus-clock domain
	// ------------------------------------------------------------
	// Command words cross by toggle handshake: hold_q stays still until done.
	typedef enum logic [1:0] {B_IDLE, B_ADDR, B_REQ, B_WAITLOW} crm_bus_st_t;

	crm_bus_st_t b_state_q;
	crm_bus_st_t b_state_d;
	logic        b_req_lvl;
	logic        b_abt_lvl;
	logic        b_req_seen_q;
	logic        b_req_seen_d;
	logic        b_abt_seen_q;
	logic        b_abt_seen_d;
	logic        b_op_wr_q;
	logic        b_op_wr_d;
	logic        b_done_tgl_q;
	logic        b_done_tgl_d;
	logic        b_rd_d;
	logic        b_wr_d;
	crm_addr_t   b_addr_d;
	crm_data_t   b_wdata_d;
	crm_data_t   b_rdata_d;
	logic        b_req_evt;
	logic        b_abt_evt;

	crm_sync u_req_sync (
		.clk_in  (cr_bus_clk_in),
		.rstn_in (rstn_in),
		.d_in    (req_tgl_q),
		.q_out   (b_req_lvl)
	);

	crm_sync u_abt_sync (
		.clk_in  (cr_bus_clk_in),
		.rstn_in (rstn_in),
		.d_in    (abt_tgl_q),
		.q_out   (b_abt_lvl)
	);

	crm_sync u_done_sync (
		.clk_in  (sys_clk_in),
		.rstn_in (rstn_in),
		.d_in    (b_done_tgl_q),
		.q_out   (done_lvl)
	);

	assign b_req_evt = (b_req_lvl != b_req_seen_q);
	assign b_abt_evt = (b_abt_lvl != b_abt_seen_q);

	always_comb begin
		b_state_d    = b_state_q;
		b_req_seen_d = b_req_seen_q;
		b_abt_seen_d = b_abt_lvl;
		b_op_wr_d    = b_op_wr_q;
		b_done_tgl_d = b_done_tgl_q;
		b_addr_d     = cr_addr_sync_out;
		b_wdata_d    = cr_wdata_sync_out;
		b_rdata_d    = b_rdata_q;
		unique case (b_state_q)
			B_IDLE: begin
				if (b_req_evt) begin
					b_req_seen_d = b_req_lvl;
					b_op_wr_d    = hold_q.write;
					b_addr_d     = hold_q.addr;
					b_wdata_d    = hold_q.wdata;
					b_state_d    = B_ADDR;
				end
			end
			B_ADDR: begin
				b_state_d = B_REQ;
			end
			B_REQ: begin
				if (cr_ack_sync_in) begin
					if (!b_op_wr_q) begin
						b_rdata_d = cr_rdata_sync_in;
					end
					b_state_d = B_WAITLOW;
				end else if (b_abt_evt) begin
					b_state_d = B_WAITLOW;
				end
			end
			B_WAITLOW: begin
				if (!cr_ack_sync_in) begin
					b_done_tgl_d = ~b_done_tgl_q;
					b_state_d    = B_IDLE;
				end
			end
		endcase
		b_rd_d = !b_op_wr_d && (b_state_d == B_REQ);
		b_wr_d = b_op_wr_d && (b_state_d == B_REQ);
	end

	always_ff @(posedge cr_bus_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			b_state_q             <= B_IDLE;
			b_req_seen_q          <= 1'b0;
			b_abt_seen_q          <= 1'b0;
			b_op_wr_q             <= 1'b0;
			b_done_tgl_q          <= 1'b0;
			b_rdata_q             <= CR_DATA_ZERO;
			cr_read_req_sync_out  <= 1'b0;
			cr_write_req_sync_out <= 1'b0;
			cr_addr_sync_out      <= CR_ADDR_RST;
			cr_wdata_sync_out     <= CR_DATA_ZERO;
		end else begin
			b_state_q             <= b_state_d;
			b_req_seen_q          <= b_req_seen_d;
			b_abt_seen_q          <= b_abt_seen_d;
			b_op_wr_q             <= b_op_wr_d;
			b_done_tgl_q          <= b_done_tgl_d;
			b_rdata_q             <= b_rdata_d;
			cr_read_req_sync_out  <= b_rd_d;
			cr_write_req_sync_out <= b_wr_d;
			cr_addr_sync_out      <= b_addr_d;
			cr_wdata_sync_out     <= b_wdata_d;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	logic req_any;
	logic b_req_any;
	assign req_any   = cr_read_req_out || cr_write_req_out;
	assign b_req_any = cr_read_req_sync_out || cr_write_req_sync_out;

	AST_REQ_AFTER_ADDR: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
		(state_q == ST_ADDR) |-> !req_any ##1 req_any) else $error("request not one cycle late");

	AST_DROP_TWO: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
		(state_q == ST_REQ) && cr_ack_in |=> req_any ##1 !req_any)
		else $error("request not dropped two cycles after ack");

	AST_NO_ABANDON: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
		(state_q == ST_REQ) && !cr_ack_in && !tmo_hit |=> req_any)
		else $error("request abandoned");

	AST_NOT_BOTH: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
		!(cr_read_req_out && cr_write_req_out)) else $error("read and write together");

	AST_READ_ZERO: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
		cr_read_req_out |-> (cr_wdata_out == CR_DATA_ZERO)) else $error("read data bus not zero");

	AST_ADDR_STABLE: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
		req_any && $past(req_any) |-> $stable(cr_addr_out) && $stable(cr_wdata_out))
		else $error("address moved during request");

	AST_ADDR_GAP: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
		$changed(cr_addr_out) |-> !$past(cr_ack_in) && !$past(req_any))
		else $error("address changed too soon");

	AST_TMO_END: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
		$rose(req_any) |-> ##[1:66] !req_any) else $error("request outlived timeout");

	AST_RESET_IDLE: assert property (@(posedge sys_clk_in)
		!rstn_in |-> !req_any && (cr_wdata_out == CR_DATA_ZERO))
		else $error("bus active in reset");

	AST_SYNC_HOLD: assert property (@(posedge cr_bus_clk_in) disable iff (!rstn_in)
		(b_state_q == B_REQ) && cr_ack_sync_in |-> b_req_any ##1 !b_req_any)
		else $error("bus request drop timing");

	AST_SYNC_RISE: assert property (@(posedge cr_bus_clk_in) disable iff (!rstn_in)
		(b_state_q == B_ADDR) |=> b_req_any && $stable(cr_addr_sync_out))
		else $error("bus request not raised");

endmodule : crm_master

`default_nettype wire

// *** test/crm_periph_model.sv ***
// Behavioural chain of control-register peripherals on one clock.
// Assumes the master's requests, address and write data are registered on clk_in.
`default_nettype none

module crm_periph_model
	import crm_pkg::*;
(
	input  wire logic       clk_in,
	input  wire logic       rstn_in,
	input  wire logic       rd_in,
	input  wire logic       wr_in,
	input  wire crm_addr_t  addr_in,
	input  wire crm_data_t  wdata_in,
	input  wire logic [3:0] dly_in,
	output var  logic       ack_out,
	output var  crm_data_t  rdata_out
);
	timeunit 1ns;
	timeprecision 1ps;

	// ------------------------------------------------------------
	// Register chain
	// ------------------------------------------------------------
	localparam crm_data_t IMPL_MASK = 32'h00FF_FFFF;
	crm_data_t  regs_q [0:15];
	logic [3:0] wait_q;
	logic       owned;

	// Only the lowest sixteen addresses live here; the rest time out
	assign owned = (addr_in[0:5] == 6'h00);
	// Upper byte unimplemented: it keeps the zero injected by the master
	assign rdata_out = (rd_in && owned)
		? ((wdata_in & ~IMPL_MASK) | (regs_q[addr_in[6:9]] & IMPL_MASK))
		: wdata_in;

	always @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			ack_out <= 1'b0;
			wait_q <= 4'h0;
			for (int i = 0; i < 16; i++) begin
				regs_q[i] <= wdata_in;
			end
		end else if (!(rd_in || wr_in)) begin
			ack_out <= 1'b0;
			wait_q <= 4'h0;
		end else if (owned && !ack_out) begin
			if (wait_q == dly_in) begin
				ack_out <= 1'b1;
				if (wr_in) begin
					regs_q[addr_in[6:9]] <= wdata_in;
				end
			end else begin
				wait_q <= wait_q + 4'h1;
			end
		end
	end
endmodule : crm_periph_model

`default_nettype wire

// *** test/tb_top.sv ***
// Self-checking bench of the control-register bus master, both variants.
// Assumes one peripheral chain model per port, each on that port's clock.
`default_nettype none

module tb_top
	import crm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic sys_clk_in = 1'b0;
	logic cr_bus_clk_in = 1'b0;
	logic rstn_in = 1'b0;
	logic mode_bus_clk_in = 1'b0;
	logic cmd_valid_in = 1'b0;
	crm_cmd_t cmd_in = CMD_RST;
	logic [3:0] dly_c = 4'h0;
	logic [3:0] dly_b = 4'h0;
	logic bus_mode = 1'b0;
	logic ready, done, tmo, rd_c, wr_c, ack_c, rd_s, wr_s, ack_s;
	crm_data_t rdata, wd_c, rd_dc, wd_s, rd_ds;
	crm_addr_t ad_c, ad_s, r_ad, prev_ad;
	crm_data_t r_wd;
	logic m_req, m_ack, prev_req, ack_prev;
	crm_addr_t m_ad;
	crm_data_t m_wd;
	int r_lead, r_req, r_hold;
	int miscompares = 0;
	int comparisons = 0;

	always #50 sys_clk_in = ~sys_clk_in;
	// Offset keeps bus edges clear of every core clock edge
	initial begin
		#3;
		forever #6 cr_bus_clk_in = ~cr_bus_clk_in;
	end

	crm_master i_crm_master (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
		.cr_bus_clk_in(cr_bus_clk_in), .mode_bus_clk_in(mode_bus_clk_in),
		.cmd_valid_in(cmd_valid_in), .cmd_in(cmd_in), .cmd_ready_out(ready),
		.cmd_done_out(done), .cmd_timeout_out(tmo), .cmd_rdata_out(rdata),
		.cr_read_req_out(rd_c), .cr_write_req_out(wr_c), .cr_addr_out(ad_c),
		.cr_wdata_out(wd_c), .cr_ack_in(ack_c), .cr_rdata_in(rd_dc),
		.cr_read_req_sync_out(rd_s), .cr_write_req_sync_out(wr_s),
		.cr_addr_sync_out(ad_s), .cr_wdata_sync_out(wd_s),
		.cr_ack_sync_in(ack_s), .cr_rdata_sync_in(rd_ds));
	// Each chain shares its port's clock, so edges coincide trivially
	crm_periph_model i_crm_periph_model_c (.clk_in(sys_clk_in), .rstn_in(rstn_in),
		.rd_in(rd_c), .wr_in(wr_c), .addr_in(ad_c), .wdata_in(wd_c), .dly_in(dly_c),
		.ack_out(ack_c), .rdata_out(rd_dc));
	crm_periph_model i_crm_periph_model_b (.clk_in(cr_bus_clk_in), .rstn_in(rstn_in),
		.rd_in(rd_s), .wr_in(wr_s), .addr_in(ad_s), .wdata_in(wd_s), .dly_in(dly_b),
		.ack_out(ack_s), .rdata_out(rd_ds));

	assign m_req = bus_mode ? (rd_s | wr_s) : (rd_c | wr_c);
	assign m_ack = bus_mode ? ack_s : ack_c;
	assign m_ad = bus_mode ? ad_s : ad_c;
	assign m_wd = bus_mode ? wd_s : wd_c;

	// ------------------------------------------------------------
	// Shared helpers
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic end_of_test;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : end_of_test

	// Port watch, sampled mid-cycle where everything has settled
	always @(negedge sys_clk_in) begin
		if (rstn_in) begin
			chk(32'((rd_c & wr_c) | (rd_s & wr_s)), 32'h0);
			chk(32'(bus_mode ? (rd_c | wr_c) : (rd_s | wr_s)), 32'h0);
			if (m_req && prev_req) begin
				chk(32'(m_ad), 32'(prev_ad));
			end
			if (!bus_mode && m_ad !== prev_ad) begin
				chk(32'(m_ack | ack_prev), 32'h0);
			end
		end
		prev_req = m_req;
		prev_ad = m_ad;
		ack_prev = m_ack;
	end

	task automatic run_cmd(input logic wr, input crm_addr_t a, input crm_data_t d);
		int n;
		n = 0;
		r_lead = 0;
		r_req = 0;
		r_hold = 0;
		@(posedge sys_clk_in);
		cmd_in <= '{write: wr, addr: a, wdata: d};
		cmd_valid_in <= 1'b1;
		// Ready is judged mid-cycle, so the taking edge is the next rising one
		@(negedge sys_clk_in);
		while (ready !== 1'b1 && n < 20) begin
			@(negedge sys_clk_in);
			n++;
		end
		@(posedge sys_clk_in);
		cmd_valid_in <= 1'b0;
		n = 0;
		@(negedge sys_clk_in);
		while (done !== 1'b1 && n < 400) begin
			if (m_req && r_req == 0) begin
				r_wd = m_wd;
				r_ad = m_ad;
			end
			if (m_req) begin
				r_req++;
			end else if (r_req == 0) begin
				r_lead++;
			end
			if (m_req && m_ack) begin
				r_hold++;
			end
			@(negedge sys_clk_in);
			n++;
		end
		chk(32'(n < 400), 32'h1);
	endtask : run_cmd

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset(input logic m);
		@(posedge sys_clk_in);
		rstn_in <= 1'b0;
		mode_bus_clk_in <= m;
		bus_mode = m;
		repeat (3) @(posedge sys_clk_in);
		chk(32'({rd_c, wr_c, rd_s, wr_s}), 32'h0);
		chk(wd_c | wd_s, CR_DATA_ZERO);
		repeat (3) @(posedge sys_clk_in);
		rstn_in <= 1'b1;
		repeat (8) @(posedge sys_clk_in);
		$display("reset test done");
	endtask : t_reset

	task automatic t_core;
		dly_c <= 4'h0;
		run_cmd(1'b1, 10'h003, 32'hA5C3_5A3C);
		chk(r_wd, 32'hA5C3_5A3C);
		chk(32'(r_lead), 32'h1);
		chk(32'(r_hold), 32'h2);
		chk(32'(r_ad), 32'h3);
		run_cmd(1'b0, 10'h003, 32'hFFFF_FFFF);
		chk(r_wd, CR_DATA_ZERO);
		chk(32'(r_lead), 32'h1);
		chk(32'(r_hold), 32'h2);
		chk(rdata, 32'h00C3_5A3C);
		run_cmd(1'b0, 10'h005, 32'h0);
		chk(rdata, CR_DATA_ZERO);
		$display("core access test done");
	endtask : t_core

	task automatic t_slow;
		dly_c <= 4'h6;
		run_cmd(1'b1, 10'h001, 32'h1234_5678);
		chk(32'(r_hold), 32'h2);
		chk(32'(r_req >= 8), 32'h1);
		run_cmd(1'b1, 10'h002, 32'h8765_4321);
		chk(32'(tmo), 32'h0);
		run_cmd(1'b0, 10'h001, 32'h0);
		chk(rdata, 32'h0034_5678);
		run_cmd(1'b0, 10'h002, 32'h0);
		chk(rdata, 32'h0065_4321);
		$display("slow back-to-back test done");
	endtask : t_slow

	task automatic t_tmo;
		for (int i = 0; i < 2; i++) begin
			run_cmd(1'b0, 10'h3FF, 32'h0);
			chk(32'(tmo), 32'h1);
			chk(32'(r_req >= 64 && r_req <= 66), 32'h1);
			chk(rdata, 32'h0065_4321);
		end
		dly_c <= 4'hF;
		run_cmd(1'b0, 10'h001, 32'h0);
		chk(32'(tmo), 32'h0);
		chk(rdata, 32'h0034_5678);
		$display("timeout test done");
	endtask : t_tmo

	task automatic t_bus;
		t_reset(1'b1);
		// Long enough that the request is seen at a core sample point
		dly_b <= 4'hF;
		run_cmd(1'b1, 10'h007, 32'hC0DE_0F0F);
		chk(r_wd, 32'hC0DE_0F0F);
		chk(32'(r_ad), 32'h7);
		chk(32'(tmo), 32'h0);
		run_cmd(1'b0, 10'h007, 32'h0);
		chk(r_wd, CR_DATA_ZERO);
		chk(rdata, 32'h00DE_0F0F);
		run_cmd(1'b1, 10'h2A0, 32'h5);
		chk(32'(tmo), 32'h1);
		$display("bus clock test done");
	endtask : t_bus

	initial begin
		t_reset(1'b0);
		t_core;
		t_slow;
		t_tmo;
		t_bus;
		end_of_test;
	end

	// Whole run needs well under half of this span
	initial begin
		#1_000_000;
		miscompares++;
		end_of_test;
	end
endmodule : tb_top

`default_nettype wire
